// [hw/cmd_decoder_pkg.sv]
// constants for the touch sensor command decoder
// Summary of operation
// - command addresses store nothing; a write only triggers its fixed action
// - action starts on the write itself, no further handshake
// - write to 0xf8 selects the on-chip oscillator as clock source
// - write to 0xf9 selects the external clock pin as clock source
// - write to 0xfa switches regulator bias off
// - write to 0xfb switches regulator bias on
// - 0xfc wakes from sleep to active; 0xfd enters sleep
// - 0xfe resets every state machine and every register
// - 0xff resets state machines and clears sleep mode; other registers keep their values
// - write to 0xff is not acknowledged but still executes
package cmd_decoder_pkg;
    localparam logic [7:0] select_internal_oscillator_cmd = 8'hf8;
    localparam logic [7:0] select_external_clock_cmd = 8'hf9;
    localparam logic [7:0] regulator_bias_disable_cmd = 8'hfa;
    localparam logic [7:0] regulator_bias_enable_cmd = 8'hfb;
    localparam logic [7:0] wake_to_active_cmd = 8'hfc;
    localparam logic [7:0] enter_sleep_cmd = 8'hfd;
    localparam logic [7:0] full_reset_cmd = 8'hfe;
    localparam logic [7:0] state_machine_reset_cmd = 8'hff;
    // reset values of the controls
    localparam logic rst_clk_external = 1'b0;
    localparam logic rst_bias_enable = 1'b1;
    localparam logic rst_sleep = 1'b0;
    localparam logic [7:0] rst_pointer = 8'h00;
    localparam logic [6:0] default_slave_addr = 7'h2c;
    localparam logic [3:0] bits_per_byte = 4'h8;
    localparam logic rw_read = 1'b1;
    typedef enum logic [3:0] {
        st_idle, st_addr, st_addr_ack, st_ptr, st_ptr_ack,
        st_wdata, st_wdata_ack, st_rdata, st_rdata_ack
    } bus_state_t;
endpackage : cmd_decoder_pkg

// [hw/touch_sensor_command_decoder.sv]
// i2c slave front end and command decoder with its control outputs
`timescale 1ns/100ps
`default_nettype none
module touch_sensor_command_decoder #(
    parameter logic [6:0] slave_addr = cmd_decoder_pkg::default_slave_addr
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    output logic select_external_clock,
    output logic bias_enable,
    output logic sleep_mode,
    output logic full_reset_pulse,
    output logic sm_reset_pulse
);
    import cmd_decoder_pkg::*;

    function automatic logic is_cmd(input logic [7:0] a);
        is_cmd = (a >= select_internal_oscillator_cmd);
    endfunction : is_cmd

    logic scl_s1_r, scl_s2_r, scl_d_r;
    logic sda_s1_r, sda_s2_r, sda_d_r;
    logic scl_rise, scl_fall, start_seen, stop_seen;
    bus_state_t state_r;
    logic [3:0] cnt_r;
    logic [7:0] shift_r;
    logic [7:0] ptr_r;
    logic read_r;
    logic oe_r;
    logic go_r;
    logic [7:0] go_cmd_r;

    // two-flop synchronisers, then one delay for edge detection
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            scl_s1_r <= 1'b1;
            scl_s2_r <= 1'b1;
            scl_d_r <= 1'b1;
            sda_s1_r <= 1'b1;
            sda_s2_r <= 1'b1;
            sda_d_r <= 1'b1;
        end else begin
            scl_s1_r <= scl_i;
            scl_s2_r <= scl_s1_r;
            scl_d_r <= scl_s2_r;
            sda_s1_r <= sda_i;
            sda_s2_r <= sda_s1_r;
            sda_d_r <= sda_s2_r;
        end
    end

    assign scl_rise = scl_s2_r && !scl_d_r;
    assign scl_fall = !scl_s2_r && scl_d_r;
    assign start_seen = scl_s2_r && scl_d_r && !sda_s2_r && sda_d_r;
    assign stop_seen = scl_s2_r && scl_d_r && sda_s2_r && !sda_d_r;

    // bus state machine
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_r <= st_idle;
            cnt_r <= 4'h0;
            shift_r <= 8'h00;
            ptr_r <= rst_pointer;
            read_r <= 1'b0;
            oe_r <= 1'b0;
            go_r <= 1'b0;
            go_cmd_r <= 8'h00;
        end else begin
            go_r <= 1'b0;
            if (go_r && go_cmd_r == full_reset_cmd) begin
                ptr_r <= rst_pointer;
            end
            if (start_seen) begin
                state_r <= st_addr;
                cnt_r <= 4'h0;
                oe_r <= 1'b0;
            end else if (stop_seen) begin
                state_r <= st_idle;
                oe_r <= 1'b0;
            end else begin
                unique case (state_r)
                    st_idle: begin
                        oe_r <= 1'b0;
                    end
                    st_addr, st_ptr, st_wdata: begin
                        if (scl_rise) begin
                            shift_r <= {shift_r[6:0], sda_s2_r};
                            cnt_r <= cnt_r + 4'h1;
                        end else if (scl_fall && cnt_r == bits_per_byte) begin
                            cnt_r <= 4'h0;
                            if (state_r == st_addr) begin
                                if (shift_r[7:1] == slave_addr) begin
                                    read_r <= shift_r[0];
                                    oe_r <= 1'b1;
                                    state_r <= st_addr_ack;
                                end else begin
                                    state_r <= st_idle;
                                end
                            end else if (state_r == st_ptr) begin
                                ptr_r <= shift_r;
                                oe_r <= 1'b1;
                                state_r <= st_ptr_ack;
                            end else begin
                                // data byte value is not looked at
                                oe_r <= (ptr_r != state_machine_reset_cmd);
                                state_r <= st_wdata_ack;
                            end
                        end
                    end
                    st_addr_ack: begin
                        if (scl_fall) begin
                            // reads of command addresses return zero
                            oe_r <= read_r;
                            state_r <= (read_r == rw_read) ? st_rdata : st_ptr;
                        end
                    end
                    st_ptr_ack: begin
                        if (scl_fall) begin
                            oe_r <= 1'b0;
                            state_r <= st_wdata;
                        end
                    end
                    st_wdata_ack: begin
                        if (scl_fall) begin
                            oe_r <= 1'b0;
                            go_r <= is_cmd(ptr_r);
                            go_cmd_r <= ptr_r;
                            // either reset returns the bus engine to idle
                            if (ptr_r == full_reset_cmd || ptr_r == state_machine_reset_cmd) begin
                                state_r <= st_idle;
                            end else begin
                                state_r <= st_wdata;
                            end
                        end
                    end
                    st_rdata: begin
                        if (scl_rise) begin
                            cnt_r <= cnt_r + 4'h1;
                        end else if (scl_fall && cnt_r == bits_per_byte) begin
                            cnt_r <= 4'h0;
                            oe_r <= 1'b0;
                            state_r <= st_rdata_ack;
                        end
                    end
                    st_rdata_ack: begin
                        if (scl_rise) begin
                            cnt_r <= sda_s2_r ? 4'h1 : 4'h0;
                        end else if (scl_fall) begin
                            if (cnt_r == 4'h1) begin
                                state_r <= st_idle;
                            end else begin
                                oe_r <= 1'b1;
                                state_r <= st_rdata;
                            end
                            cnt_r <= 4'h0;
                        end
                    end
                    default: begin
                        state_r <= st_idle;
                    end
                endcase
            end
        end
    end

    // clock source select
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            select_external_clock <= rst_clk_external;
        end else if (go_r) begin
            if (go_cmd_r == select_internal_oscillator_cmd) begin
                select_external_clock <= 1'b0;
            end else if (go_cmd_r == select_external_clock_cmd) begin
                select_external_clock <= 1'b1;
            end else if (go_cmd_r == full_reset_cmd) begin
                select_external_clock <= rst_clk_external;
            end
        end
    end

    // regulator bias
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            bias_enable <= rst_bias_enable;
        end else if (go_r) begin
            if (go_cmd_r == regulator_bias_disable_cmd) begin
                bias_enable <= 1'b0;
            end else if (go_cmd_r == regulator_bias_enable_cmd) begin
                bias_enable <= 1'b1;
            end else if (go_cmd_r == full_reset_cmd) begin
                bias_enable <= rst_bias_enable;
            end
        end
    end

    // power state
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sleep_mode <= rst_sleep;
        end else if (go_r) begin
            if (go_cmd_r == wake_to_active_cmd) begin
                sleep_mode <= 1'b0;
            end else if (go_cmd_r == enter_sleep_cmd) begin
                sleep_mode <= 1'b1;
            end else if (go_cmd_r == full_reset_cmd || go_cmd_r == state_machine_reset_cmd) begin
                sleep_mode <= rst_sleep;
            end
        end
    end

    // reset strobes to the rest of the device
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            full_reset_pulse <= 1'b0;
            sm_reset_pulse <= 1'b0;
        end else begin
            full_reset_pulse <= go_r && go_cmd_r == full_reset_cmd;
            sm_reset_pulse <= go_r && (go_cmd_r == state_machine_reset_cmd ||
                go_cmd_r == full_reset_cmd);
        end
    end

    // open-drain pad: only ever drives low
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sda_o <= 1'b0;
            sda_oe <= 1'b0;
        end else begin
            sda_o <= 1'b0;
            sda_oe <= oe_r;
        end
    end
endmodule : touch_sensor_command_decoder
`default_nettype wire

// [test/cmd_decoder_props.sv]
// port assertions for the command decoder
`timescale 1ns/100ps
`default_nettype none
module cmd_decoder_props (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic sda_o,
    input wire logic sda_oe,
    input wire logic select_external_clock,
    input wire logic bias_enable,
    input wire logic sleep_mode,
    input wire logic full_reset_pulse,
    input wire logic sm_reset_pulse
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    pad_low_a: assert property (sda_oe |-> sda_o == 1'b0) else $error("sda pad high");
    full_pulse_a: assert property (full_reset_pulse |=> !full_reset_pulse) else $error("full pulse long");
    sm_pulse_a: assert property (sm_reset_pulse |=> !sm_reset_pulse) else $error("sm pulse long");
    full_sm_a: assert property (full_reset_pulse |-> sm_reset_pulse) else $error("no sm pulse");
    full_restore_a: assert property (full_reset_pulse |-> ##[0:3] (bias_enable && !sleep_mode
        && !select_external_clock)) else $error("controls not restored");
    warm_wake_a: assert property (sm_reset_pulse |-> ##[0:3] !sleep_mode) else $error("no wake");
    warm_keep_a: assert property (sm_reset_pulse && !full_reset_pulse |=> $stable(bias_enable)
        && $stable(select_external_clock)) else $error("warm reset lost controls");
    oe_steady_a: assert property (scl_i && $past(scl_i) |-> $stable(sda_oe)) else $error("sda moved");
    ack_hold_a: assert property ($rose(sda_oe) |=> sda_oe [*8]) else $error("ack too short");
endmodule : cmd_decoder_props
bind touch_sensor_command_decoder cmd_decoder_props chk (.clk(clk), .rst_n(rst_n), .scl_i(scl_i),
    .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe), .select_external_clock(select_external_clock),
    .bias_enable(bias_enable), .sleep_mode(sleep_mode), .full_reset_pulse(full_reset_pulse),
    .sm_reset_pulse(sm_reset_pulse));
`default_nettype wire

// [test/host_i2c_master.sv]
// host bus master model issuing command writes
`timescale 1ns/100ps
`default_nettype none
module host_i2c_master (
    input wire logic clk,
    output logic scl,
    output logic sda_low,
    input wire logic sda_wire
);
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    task automatic put(input logic b);
        sda_low <= !b;
        repeat (4) @(posedge clk);
        scl <= 1'b1;
        repeat (8) @(posedge clk);
        scl <= 1'b0;
        repeat (4) @(posedge clk);
    endtask : put
    task automatic get_ack(output logic ack);
        sda_low <= 1'b0;
        repeat (4) @(posedge clk);
        scl <= 1'b1;
        repeat (4) @(posedge clk);
        ack = !sda_wire;
        repeat (4) @(posedge clk);
        scl <= 1'b0;
        repeat (4) @(posedge clk);
    endtask : get_ack
    task automatic send_byte(input logic [7:0] v, output logic ack);
        for (int i = 7; i >= 0; i--) put(v[i]);
        get_ack(ack);
    endtask : send_byte
    // start, address, pointer, dummy byte, stop; a missing ack never aborts
    task automatic write3(input logic [6:0] a, input logic [7:0] p, input logic [7:0] d,
            output logic [2:0] acks);
        sda_low <= 1'b1;
        repeat (8) @(posedge clk);
        scl <= 1'b0;
        repeat (4) @(posedge clk);
        send_byte({a, 1'b0}, acks[2]);
        send_byte(p, acks[1]);
        send_byte(d, acks[0]);
        sda_low <= 1'b1;
        repeat (4) @(posedge clk);
        scl <= 1'b1;
        repeat (8) @(posedge clk);
        sda_low <= 1'b0;
        repeat (16) @(posedge clk);
    endtask : write3
    // start, address with read bit, one byte read, master nack, stop
    task automatic read1(input logic [6:0] a, output logic ack, output logic [7:0] v);
        logic b;
        sda_low <= 1'b1;
        repeat (8) @(posedge clk);
        scl <= 1'b0;
        repeat (4) @(posedge clk);
        send_byte({a, 1'b1}, ack);
        for (int i = 7; i >= 0; i--) begin
            get_ack(b);
            v[i] = !b;
        end
        put(1'b1);
        sda_low <= 1'b1;
        repeat (4) @(posedge clk);
        scl <= 1'b1;
        repeat (8) @(posedge clk);
        sda_low <= 1'b0;
        repeat (16) @(posedge clk);
    endtask : read1
endmodule : host_i2c_master
`default_nettype wire

// [test/testbench.sv]
// self-checking bench for the command decoder
`timescale 1ns/100ps
`default_nettype none
module testbench;
    import cmd_decoder_pkg::*;
    typedef struct packed {logic [7:0] p; logic [7:0] d; logic [2:0] st; logic ack;} row_t;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic scl, sda_low, sda_wire, sda_o, sda_oe, ext, bias, slp, fp, sp;
    int err_total = 0;
    int checked = 0;
    int n_full = 0;
    int n_sm = 0;
    row_t rows [8] = '{'{8'hf9, 8'ha5, 3'b110, 1'b1}, '{8'hfa, 8'h00, 3'b100, 1'b1},
        '{8'hfd, 8'hff, 3'b101, 1'b1}, '{8'hff, 8'h11, 3'b100, 1'b0},
        '{8'hfd, 8'h5a, 3'b101, 1'b1}, '{8'hfc, 8'h3c, 3'b100, 1'b1},
        '{8'hfb, 8'h81, 3'b110, 1'b1}, '{8'hf8, 8'h00, 3'b010, 1'b1}};
    always #2 clk = ~clk;
    assign sda_wire = !(sda_oe || sda_low);
    always @(posedge clk) begin
        if (fp === 1'b1) n_full++;
        if (sp === 1'b1) n_sm++;
    end
    touch_sensor_command_decoder dut (.clk(clk), .rst_n(rst_n), .scl_i(scl), .sda_i(sda_wire),
        .sda_o(sda_o), .sda_oe(sda_oe), .select_external_clock(ext), .bias_enable(bias),
        .sleep_mode(slp), .full_reset_pulse(fp), .sm_reset_pulse(sp));
    host_i2c_master host (.clk(clk), .scl(scl), .sda_low(sda_low), .sda_wire(sda_wire));
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic report_and_stop;
        if (err_total == 0 && checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : report_and_stop
    task automatic wr(input logic [6:0] a, input logic [7:0] p, input logic [2:0] ex);
        logic [2:0] k;
        host.write3(a, p, 8'h69, k);
        check({5'h0, k}, {5'h0, ex});
    endtask : wr
    initial begin
        repeat (20000) @(posedge clk);
        err_total++;
        report_and_stop();
    end
    initial begin
        logic [2:0] k;
        logic ra;
        logic [7:0] rv;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        check({5'h0, ext, bias, slp}, 8'h02);
        foreach (rows[i]) begin
            host.write3(default_slave_addr, rows[i].p, rows[i].d, k);
            check({5'h0, ext, bias, slp}, {5'h0, rows[i].st});
            check({5'h0, k}, {5'h0, 2'b11, rows[i].ack});
        end
        check(8'(n_sm), 8'h01);
        wr(default_slave_addr, 8'h10, 3'b111);
        check({5'h0, ext, bias, slp}, 8'h02);
        wr(default_slave_addr ^ 7'h01, 8'hfd, 3'b000);
        check({5'h0, ext, bias, slp}, 8'h02);
        wr(default_slave_addr, 8'hf9, 3'b111);
        wr(default_slave_addr, 8'hfa, 3'b111);
        wr(default_slave_addr, 8'hfd, 3'b111);
        check({5'h0, ext, bias, slp}, 8'h05);
        wr(default_slave_addr, 8'hfe, 3'b111);
        check({5'h0, ext, bias, slp}, 8'h02);
        check(8'(n_full), 8'h01);
        check(8'(n_sm), 8'h02);
        wr(default_slave_addr, 8'hf9, 3'b111);
        rst_n <= 1'b0;
        repeat (4) @(posedge clk);
        check({5'h0, ext, bias, slp}, 8'h02);
        rst_n <= 1'b1;
        repeat (8) @(posedge clk);
        host.read1(default_slave_addr, ra, rv);
        check({7'h0, ra}, 8'h01);
        check(rv, 8'h00);
        check({5'h0, ext, bias, slp}, 8'h02);
        report_and_stop();
    end
endmodule : testbench
`default_nettype wire
